// File: rtl/cmd_decoder_pkg.sv
// constants, types and layouts shared by the addressed command decoder
// Summary of operation
// - 12-bit bunch counter advances once per recovered link clock cycle.
// - Bunch counter clears on broadcast clear, management write, and initialisation.
// - 24-bit event counter advances once per trigger accept on the first channel.
// - Event counter clears on broadcast clear, management write, and initialisation.
// - Status bits 3..0 read zero; bit 4 shows a watchdog automatic reset.
// - Status bits 5, 6, 7 show frame lock, phase shifter health, clock lock.
// - Status holds no storage; a write to it triggers a special action instead.
// - Command carries 14-bit target, 8-bit data byte and 8-bit subaddress byte.
// - Accepted command is internal with scope bit 0, external with scope bit 1.
// - External command drives data and subaddress buses, qualified by the output strobe.
// - Internal subaddress 0 to 3 writes fine one, fine two, coarse, control.
// - Internal subaddress 4, 5, 6 runs a command and ignores the data byte.
// - Target identifier zero is accepted by every receiver.
// - Error dump outputs four counter bytes on consecutive cycles, qualifiers 1 to 4.
// - Output strobe is high whenever a dump places valid data on the bus.
// - Config dump outputs delays, control, identifier bytes with qualifiers 5 to 10.
// - Subaddress 6 requests full chip reset, only while clock recovery is locked.
// - Broadcast bit 0 clears bunch counter, bit 1 event counter, both clear both.
// - Single-bit error counter stops at 65535, double-bit counter at 256, SEU counter at 255.
package cmd_decoder_pkg;

    localparam int BUNCH_W = 12;
    localparam int EVENT_W = 24;
    localparam int ID_W = 14;

    // internal subaddress map
    localparam logic [7:0] SUB_FINE_ONE = 8'h00;
    localparam logic [7:0] SUB_FINE_TWO = 8'h01;
    localparam logic [7:0] SUB_COARSE = 8'h02;
    localparam logic [7:0] SUB_CONTROL = 8'h03;
    localparam logic [7:0] SUB_ERR_DUMP = 8'h04;
    localparam logic [7:0] SUB_CFG_DUMP = 8'h05;
    localparam logic [7:0] SUB_RESET = 8'h06;
    localparam logic [7:0] STATUS_ADDR = 8'h16;

    localparam logic [ID_W-1:0] GLOBAL_ID = 14'h0000;

    // data qualifier codes
    localparam logic [3:0] Q_EXTERNAL = 4'h0;
    localparam logic [3:0] Q_SBE_LO = 4'h1;
    localparam logic [3:0] Q_SBE_HI = 4'h2;
    localparam logic [3:0] Q_DBE_LO = 4'h3;
    localparam logic [3:0] Q_SEU = 4'h4;
    localparam logic [3:0] Q_FINE_ONE = 4'h5;
    localparam logic [3:0] Q_FINE_TWO = 4'h6;
    localparam logic [3:0] Q_COARSE = 4'h7;
    localparam logic [3:0] Q_CONTROL = 4'h8;
    localparam logic [3:0] Q_ID_LO = 4'h9;
    localparam logic [3:0] Q_ID_HI = 4'hA;

    localparam logic [2:0] ERR_DUMP_LEN = 3'h4;
    localparam logic [2:0] CFG_DUMP_LEN = 3'h6;

    // error counter ceilings
    localparam logic [15:0] SBE_MAX = 16'hFFFF;
    localparam logic [8:0] DBE_MAX = 9'h100;
    localparam logic [7:0] SEU_MAX = 8'hFF;

    // status bit positions
    localparam int STAT_AUTO_RESET = 4;
    localparam int STAT_FRAME_LOCK = 5;
    localparam int STAT_DLL_READY = 6;
    localparam int STAT_PLL_READY = 7;
    localparam logic [3:0] STAT_ZERO_BITS = 4'h0;

    // broadcast byte bit positions
    localparam int BCAST_BUNCH_BIT = 0;
    localparam int BCAST_EVENT_BIT = 1;

    // reset values
    localparam logic [7:0] FINE_ONE_RST = 8'h00;
    localparam logic [7:0] FINE_TWO_RST = 8'h00;
    localparam logic [7:0] COARSE_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;

    typedef struct packed {
        logic [ID_W-1:0] target_id;
        logic scope;
        logic [7:0] data;
        logic [7:0] subaddr;
    } addr_cmd_t;

    typedef struct packed {
        logic [3:0] qualifier;
        logic [7:0] subaddr;
        logic [7:0] data;
    } out_word_t;

    typedef enum logic [1:0] {
        DUMP_IDLE = 2'b00,
        DUMP_ERR = 2'b01,
        DUMP_CFG = 2'b10
    } dump_state_t;

endpackage

// File: rtl/pulse_crossing.sv
// toggle based single-cycle pulse crossing between two clock domains
`timescale 1ns/100ps
`default_nettype none
module pulse_crossing (
    input wire logic src_clk,
    input wire logic src_resetn,
    input wire logic src_pulse,
    input wire logic dst_clk,
    input wire logic dst_resetn,
    output logic dst_pulse
);

    logic src_toggle_ff;
    logic dst_meta_ff;
    logic dst_sync_ff;
    logic dst_seen_ff;

    always_ff @(posedge src_clk)
    begin
        if (!src_resetn)
            src_toggle_ff <= 1'b0;
        else if (src_pulse)
            src_toggle_ff <= ~src_toggle_ff;
    end

    always_ff @(posedge dst_clk)
    begin
        if (!dst_resetn)
        begin
            dst_meta_ff <= 1'b0;
            dst_sync_ff <= 1'b0;
            dst_seen_ff <= 1'b0;
        end
        else
        begin
            dst_meta_ff <= src_toggle_ff;
            dst_sync_ff <= dst_meta_ff;
            dst_seen_ff <= dst_sync_ff;
        end
    end

    assign dst_pulse = dst_sync_ff ^ dst_seen_ff;

endmodule
`default_nettype wire

// File: rtl/addressed_command_decoder.sv
// addressed command decoder with counters, dumps and health status
`timescale 1ns/100ps
`default_nettype none
module addressed_command_decoder #(
    parameter int BUNCH_W = cmd_decoder_pkg::BUNCH_W,
    parameter int EVENT_W = cmd_decoder_pkg::EVENT_W
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic link_clk,
    // link side, decoded frames on the recovered clock
    input wire logic bcast_strobe,
    input wire logic [7:0] bcast_byte,
    input wire logic trigger_accept,
    input wire logic cmd_valid,
    input wire cmd_decoder_pkg::addr_cmd_t cmd,
    input wire logic sbe_event,
    input wire logic dbe_event,
    input wire logic seu_event,
    input wire logic [15:0] hardwired_identifier_bus,
    output cmd_decoder_pkg::out_word_t out_word,
    output logic output_byte_strobe,
    output logic [BUNCH_W-1:0] bunch_count,
    output logic [EVENT_W-1:0] event_count,
    output logic [7:0] fine_delay_one,
    output logic [7:0] fine_delay_two,
    output logic [7:0] coarse_delay,
    output logic [7:0] control,
    // core side, management access and health pins
    input wire logic bunch_count_wr,
    input wire logic event_count_wr,
    input wire logic status_wr,
    input wire logic pll_lock_pin,
    input wire logic dll_ready_pin,
    input wire logic frame_lock_pin,
    input wire logic watchdog_reset_pin,
    output logic [7:0] health_status,
    output logic status_write_action,
    output logic chip_reset_request
);

    generate
        if (BUNCH_W < 1 || BUNCH_W > 32)
        begin : g_bad_bunch
            $error("bunch counter width out of range");
        end
        if (EVENT_W < 1 || EVENT_W > 32)
        begin : g_bad_event
            $error("event counter width out of range");
        end
    endgenerate

    // link domain reset, taken from the core reset level
    logic link_rst_meta_ff;
    logic link_rst_sync_ff;

    always_ff @(posedge link_clk)
    begin
        link_rst_meta_ff <= resetn;
        link_rst_sync_ff <= link_rst_meta_ff;
    end

    wire link_resetn = link_rst_sync_ff;

    // identifier straps, synchronised then caught once after release
    logic [15:0] id_meta_ff;
    logic [15:0] id_sync_ff;
    logic [cmd_decoder_pkg::ID_W-1:0] id_ff;
    logic id_loaded_ff;

    always_ff @(posedge link_clk)
    begin
        id_meta_ff <= hardwired_identifier_bus;
        id_sync_ff <= id_meta_ff;
    end

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            id_ff <= cmd_decoder_pkg::GLOBAL_ID;
            id_loaded_ff <= 1'b0;
        end
        else if (!id_loaded_ff)
        begin
            id_ff <= id_sync_ff[cmd_decoder_pkg::ID_W-1:0];
            id_loaded_ff <= 1'b1;
        end
    end

    // management writes crossing into the link domain
    wire bunch_wr_link;
    wire event_wr_link;
    wire reset_cmd_core;

    pulse_crossing u_bunch_wr (
        .src_clk(core_clk),
        .src_resetn(resetn),
        .src_pulse(bunch_count_wr),
        .dst_clk(link_clk),
        .dst_resetn(link_resetn),
        .dst_pulse(bunch_wr_link)
    );

    pulse_crossing u_event_wr (
        .src_clk(core_clk),
        .src_resetn(resetn),
        .src_pulse(event_count_wr),
        .dst_clk(link_clk),
        .dst_resetn(link_resetn),
        .dst_pulse(event_wr_link)
    );

    // command decode
    cmd_decoder_pkg::dump_state_t state_ff;
    cmd_decoder_pkg::dump_state_t nxt_state;
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;

    function automatic logic sub_is(input logic [7:0] sub, input logic [7:0] code);
        sub_is = (sub == code);
    endfunction

    wire dump_idle = (state_ff == cmd_decoder_pkg::DUMP_IDLE);
    wire id_match = (cmd.target_id == id_ff) || (cmd.target_id == cmd_decoder_pkg::GLOBAL_ID);
    wire cmd_accept = cmd_valid && id_loaded_ff && id_match && dump_idle;
    wire internal_cmd = cmd_accept && !cmd.scope;
    wire external_cmd = cmd_accept && cmd.scope;
    wire wr_fine_one = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_FINE_ONE);
    wire wr_fine_two = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_FINE_TWO);
    wire wr_coarse = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_COARSE);
    wire wr_control = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_CONTROL);
    wire start_err = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_ERR_DUMP);
    wire start_cfg = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_CFG_DUMP);
    wire reset_cmd = internal_cmd && sub_is(cmd.subaddr, cmd_decoder_pkg::SUB_RESET);

    // internally written registers
    logic [7:0] fine_one_ff;
    logic [7:0] fine_two_ff;
    logic [7:0] coarse_ff;
    logic [7:0] control_ff;

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            fine_one_ff <= cmd_decoder_pkg::FINE_ONE_RST;
            fine_two_ff <= cmd_decoder_pkg::FINE_TWO_RST;
            coarse_ff <= cmd_decoder_pkg::COARSE_RST;
            control_ff <= cmd_decoder_pkg::CONTROL_RST;
        end
        else
        begin
            if (wr_fine_one)
                fine_one_ff <= cmd.data;
            if (wr_fine_two)
                fine_two_ff <= cmd.data;
            if (wr_coarse)
                coarse_ff <= cmd.data;
            if (wr_control)
                control_ff <= cmd.data;
        end
    end

    // bunch and event counters
    logic [BUNCH_W-1:0] bunch_ff;
    logic [EVENT_W-1:0] event_ff;

    wire bunch_clear = (bcast_strobe && bcast_byte[cmd_decoder_pkg::BCAST_BUNCH_BIT]) || bunch_wr_link;
    wire event_clear = (bcast_strobe && bcast_byte[cmd_decoder_pkg::BCAST_EVENT_BIT]) || event_wr_link;
    wire [BUNCH_W-1:0] nxt_bunch = bunch_clear ? '0 : bunch_ff + 1'b1;
    wire [EVENT_W-1:0] nxt_event = event_clear ? '0 : event_ff + 1'b1;

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            bunch_ff <= '0;
            event_ff <= '0;
        end
        else
        begin
            bunch_ff <= nxt_bunch;
            if (event_clear || trigger_accept)
                event_ff <= nxt_event;
        end
    end

    // saturating error counters, reactivated only by initialisation
    logic [15:0] sbe_ff;
    logic [8:0] dbe_ff;
    logic [7:0] seu_ff;

    wire sbe_inc = sbe_event && (sbe_ff != cmd_decoder_pkg::SBE_MAX);
    wire dbe_inc = dbe_event && (dbe_ff != cmd_decoder_pkg::DBE_MAX);
    wire seu_inc = seu_event && (seu_ff != cmd_decoder_pkg::SEU_MAX);

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            sbe_ff <= 16'h0000;
            dbe_ff <= 9'h000;
            seu_ff <= 8'h00;
        end
        else
        begin
            if (sbe_inc)
                sbe_ff <= sbe_ff + 16'h0001;
            if (dbe_inc)
                dbe_ff <= dbe_ff + 9'h001;
            if (seu_inc)
                seu_ff <= seu_ff + 8'h01;
        end
    end

    // dump sequencer, one item per link cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        case (state_ff)
            cmd_decoder_pkg::DUMP_IDLE:
            begin
                nxt_idx = 3'h0;
                if (start_err)
                    nxt_state = cmd_decoder_pkg::DUMP_ERR;
                else if (start_cfg)
                    nxt_state = cmd_decoder_pkg::DUMP_CFG;
            end
            cmd_decoder_pkg::DUMP_ERR:
            begin
                nxt_idx = idx_ff + 3'h1;
                if (idx_ff == cmd_decoder_pkg::ERR_DUMP_LEN - 3'h1)
                    nxt_state = cmd_decoder_pkg::DUMP_IDLE;
            end
            cmd_decoder_pkg::DUMP_CFG:
            begin
                nxt_idx = idx_ff + 3'h1;
                if (idx_ff == cmd_decoder_pkg::CFG_DUMP_LEN - 3'h1)
                    nxt_state = cmd_decoder_pkg::DUMP_IDLE;
            end
            default:
            begin
                nxt_state = cmd_decoder_pkg::DUMP_IDLE;
                nxt_idx = 3'h0;
            end
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            state_ff <= cmd_decoder_pkg::DUMP_IDLE;
            idx_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    // dump item selection
    function automatic logic [11:0] err_item(input logic [2:0] idx, input logic [15:0] sbe,
                                             input logic [8:0] dbe, input logic [7:0] seu);
        case (idx)
            3'h0: err_item = {cmd_decoder_pkg::Q_SBE_LO, sbe[7:0]};
            3'h1: err_item = {cmd_decoder_pkg::Q_SBE_HI, sbe[15:8]};
            3'h2: err_item = {cmd_decoder_pkg::Q_DBE_LO, dbe[7:0]};
            default: err_item = {cmd_decoder_pkg::Q_SEU, seu};
        endcase
    endfunction

    function automatic logic [11:0] cfg_item(input logic [2:0] idx, input logic [7:0] f1,
                                             input logic [7:0] f2, input logic [7:0] cd,
                                             input logic [7:0] ct, input logic [13:0] id);
        case (idx)
            3'h0: cfg_item = {cmd_decoder_pkg::Q_FINE_ONE, f1};
            3'h1: cfg_item = {cmd_decoder_pkg::Q_FINE_TWO, f2};
            3'h2: cfg_item = {cmd_decoder_pkg::Q_COARSE, cd};
            3'h3: cfg_item = {cmd_decoder_pkg::Q_CONTROL, ct};
            3'h4: cfg_item = {cmd_decoder_pkg::Q_ID_LO, id[7:0]};
            default: cfg_item = {cmd_decoder_pkg::Q_ID_HI, 2'b00, id[13:8]};
        endcase
    endfunction

    wire [11:0] err_sel = err_item(idx_ff, sbe_ff, dbe_ff, seu_ff);
    wire [11:0] cfg_sel = cfg_item(idx_ff, fine_one_ff, fine_two_ff, coarse_ff, control_ff, id_ff);
    wire dump_err = (state_ff == cmd_decoder_pkg::DUMP_ERR);
    wire dump_cfg = (state_ff == cmd_decoder_pkg::DUMP_CFG);

    // output bus
    cmd_decoder_pkg::out_word_t out_ff;
    cmd_decoder_pkg::out_word_t nxt_out;
    logic strobe_ff;

    always_comb
    begin
        nxt_out = out_ff;
        if (dump_err)
            nxt_out = '{qualifier: err_sel[11:8], subaddr: 8'h00, data: err_sel[7:0]};
        else if (dump_cfg)
            nxt_out = '{qualifier: cfg_sel[11:8], subaddr: 8'h00, data: cfg_sel[7:0]};
        else if (external_cmd)
            nxt_out = '{qualifier: cmd_decoder_pkg::Q_EXTERNAL, subaddr: cmd.subaddr, data: cmd.data};
    end

    wire nxt_strobe = dump_err || dump_cfg || external_cmd;

    always_ff @(posedge link_clk)
    begin
        if (!link_resetn)
        begin
            out_ff <= '0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            out_ff <= nxt_out;
            strobe_ff <= nxt_strobe;
        end
    end

    // reset request to the core domain
    pulse_crossing u_reset_cmd (
        .src_clk(link_clk),
        .src_resetn(link_resetn),
        .src_pulse(reset_cmd),
        .dst_clk(core_clk),
        .dst_resetn(resetn),
        .dst_pulse(reset_cmd_core)
    );

    // health pins, synchronised in the core domain
    logic [3:0] health_meta_ff;
    logic [3:0] health_sync_ff;

    always_ff @(posedge core_clk)
    begin
        health_meta_ff <= {pll_lock_pin, dll_ready_pin, frame_lock_pin, watchdog_reset_pin};
        health_sync_ff <= health_meta_ff;
    end

    wire pll_locked = health_sync_ff[3];

    logic status_action_ff;
    logic reset_req_ff;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            status_action_ff <= 1'b0;
            reset_req_ff <= 1'b0;
        end
        else
        begin
            status_action_ff <= status_wr;
            reset_req_ff <= reset_cmd_core && pll_locked;
        end
    end

    // status is assembled from live levels, nothing stored
    always_comb
    begin
        health_status = 8'h00;
        health_status[3:0] = cmd_decoder_pkg::STAT_ZERO_BITS;
        health_status[cmd_decoder_pkg::STAT_AUTO_RESET] = health_sync_ff[0];
        health_status[cmd_decoder_pkg::STAT_FRAME_LOCK] = health_sync_ff[1];
        health_status[cmd_decoder_pkg::STAT_DLL_READY] = health_sync_ff[2];
        health_status[cmd_decoder_pkg::STAT_PLL_READY] = health_sync_ff[3];
    end

    assign out_word = out_ff;
    assign output_byte_strobe = strobe_ff;
    assign bunch_count = bunch_ff;
    assign event_count = event_ff;
    assign fine_delay_one = fine_one_ff;
    assign fine_delay_two = fine_two_ff;
    assign coarse_delay = coarse_ff;
    assign control = control_ff;
    assign status_write_action = status_action_ff;
    assign chip_reset_request = reset_req_ff;

endmodule
`default_nettype wire

// File: test/cmd_decoder_monitor.sv
// assertion checker on the addressed command decoder ports
`timescale 1ns/100ps
`default_nettype none
module cmd_decoder_monitor #(
    parameter int BUNCH_W = 12,
    parameter int EVENT_W = 24
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic bcast_strobe,
    input wire logic [7:0] bcast_byte,
    input wire logic trigger_accept,
    input wire logic cmd_valid,
    input wire cmd_decoder_pkg::addr_cmd_t cmd,
    input wire logic [15:0] hardwired_identifier_bus,
    input wire cmd_decoder_pkg::out_word_t out_word,
    input wire logic output_byte_strobe,
    input wire logic [BUNCH_W-1:0] bunch_count,
    input wire logic [EVENT_W-1:0] event_count,
    input wire logic [7:0] fine_delay_one,
    input wire logic status_wr,
    input wire logic pll_lock_pin,
    input wire logic dll_ready_pin,
    input wire logic frame_lock_pin,
    input wire logic watchdog_reset_pin,
    input wire logic [7:0] health_status,
    input wire logic status_write_action
);
    wire logic hit = cmd_valid && (cmd.target_id == 14'h0000 || cmd.target_id == hardwired_identifier_bus[13:0]);
    wire logic int_go = hit && !cmd.scope;
    wire logic [4:0] sq = {output_byte_strobe, out_word.qualifier};

    bunch_step_a: assert property (@(posedge link_clk) disable iff (!resetn)
        bunch_count != $past(bunch_count) + 1'b1 |-> bunch_count == '0) else $error("bunch skip");
    bunch_clear_a: assert property (@(posedge link_clk) disable iff (!resetn)
        bcast_strobe && bcast_byte[0] |=> bunch_count == '0) else $error("bunch not cleared");
    event_clear_a: assert property (@(posedge link_clk) disable iff (!resetn)
        bcast_strobe && bcast_byte[1] |=> event_count == '0) else $error("event not cleared");
    event_step_a: assert property (@(posedge link_clk) disable iff (!resetn)
        trigger_accept && !(bcast_strobe && bcast_byte[1]) |=> event_count == $past(event_count) + 1'b1)
        else $error("event no step");
    ext_out_a: assert property (@(posedge link_clk) disable iff (!resetn)
        hit && cmd.scope |=> sq == 5'h10 && {out_word.subaddr, out_word.data} == $past({cmd.subaddr, cmd.data}))
        else $error("external word");
    reg_write_a: assert property (@(posedge link_clk) disable iff (!resetn)
        int_go && cmd.subaddr == 8'h00 |=> fine_delay_one == $past(cmd.data)) else $error("register write");
    foreign_id_a: assert property (@(posedge link_clk) disable iff (!resetn)
        cmd_valid && !hit |=> !output_byte_strobe[*3]) else $error("foreign command");
    err_dump_a: assert property (@(posedge link_clk) disable iff (!resetn)
        int_go && cmd.subaddr == 8'h04 |=> !output_byte_strobe ##1 sq == 5'h11 ##1 sq == 5'h12
        ##1 sq == 5'h13 ##1 sq == 5'h14 ##1 !output_byte_strobe) else $error("error dump");
    cfg_dump_a: assert property (@(posedge link_clk) disable iff (!resetn)
        int_go && cmd.subaddr == 8'h05 |=> !output_byte_strobe ##1 sq == 5'h15 ##1 sq == 5'h16 ##1 sq == 5'h17
        ##1 sq == 5'h18 ##1 sq == 5'h19 ##1 sq == 5'h1A ##1 !output_byte_strobe) else $error("config dump");
    status_bits_a: assert property (@(posedge core_clk) disable iff (!resetn)
        health_status == {$past({pll_lock_pin, dll_ready_pin, frame_lock_pin, watchdog_reset_pin}, 2), 4'h0})
        else $error("status bits");
    status_act_a: assert property (@(posedge core_clk) disable iff (!resetn)
        status_wr |=> status_write_action ##1 !status_write_action) else $error("status action");

    ext_c: cover property (@(posedge link_clk) hit && cmd.scope);
    err_c: cover property (@(posedge link_clk) int_go && cmd.subaddr == 8'h04);
    cfg_c: cover property (@(posedge link_clk) int_go && cmd.subaddr == 8'h05);
endmodule
`default_nettype wire

// File: test/link_transmitter.sv
// behavioural link transmitter feeding decoded frames and events
`timescale 1ns/100ps
`default_nettype none
module link_transmitter (
    input wire logic link_clk,
    output logic bcast_strobe,
    output logic [7:0] bcast_byte,
    output logic trigger_accept,
    output logic cmd_valid,
    output var cmd_decoder_pkg::addr_cmd_t cmd,
    output logic [2:0] err_event
);
    initial
    begin
        {bcast_strobe, bcast_byte, trigger_accept, cmd_valid, cmd, err_event} = '0;
    end

    // idle fields show the inverse of the last frame
    task automatic send_cmd(input logic [13:0] id, input logic e, input logic [7:0] d, input logic [7:0] sub);
        @(posedge link_clk);
        cmd_valid <= 1'b1;
        cmd <= {id, e, d, sub};
        @(posedge link_clk);
        cmd_valid <= 1'b0;
        cmd <= ~cmd;
    endtask

    task automatic bcast(input logic [7:0] b);
        @(posedge link_clk);
        bcast_strobe <= 1'b1;
        bcast_byte <= b;
        @(posedge link_clk);
        bcast_strobe <= 1'b0;
        bcast_byte <= ~b;
    endtask

    // k 0..2 error events, 3 trigger accept
    task automatic pulse(input int k);
        @(posedge link_clk);
        {trigger_accept, err_event} <= 4'h1 << k;
        @(posedge link_clk);
        {trigger_accept, err_event} <= 4'h0;
    endtask
endmodule
`default_nettype wire

// File: test/test_addressed_command_decoder.sv
// testbench for the addressed command decoder
`timescale 1ns/100ps
`default_nettype none
module test_addressed_command_decoder;
    localparam logic [15:0] MY_ID = 16'hC1A5;
    logic core_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, watchdog_reset_pin = 1'b0;
    logic [2:0] mgmt = 3'h0;
    logic pll_lock_pin = 1'b1, dll_ready_pin = 1'b1, frame_lock_pin = 1'b1;
    logic bcast_strobe, trigger_accept, cmd_valid, output_byte_strobe, status_write_action, chip_reset_request;
    logic [7:0] bcast_byte, fine_delay_one, fine_delay_two, coarse_delay, control, health_status;
    logic [2:0] err_event;
    logic [11:0] bunch_count;
    logic [23:0] event_count;
    cmd_decoder_pkg::addr_cmd_t cmd;
    cmd_decoder_pkg::out_word_t out_word;
    int n_errors = 0, check_count = 0, cycles = 0;

    always #20 core_clk = ~core_clk;
    always #24 link_clk = ~link_clk;

    addressed_command_decoder u_dut (.*, .sbe_event(err_event[0]), .dbe_event(err_event[1]), .seu_event(err_event[2]),
        .hardwired_identifier_bus(MY_ID), .bunch_count_wr(mgmt[0]), .event_count_wr(mgmt[1]), .status_wr(mgmt[2]));
    link_transmitter u_tx (.*);

    task automatic stop_test();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic core_pulse(input int k);
        @(posedge core_clk);
        mgmt <= 3'h1 << k;
        @(posedge core_clk);
        mgmt <= 3'h0;
    endtask

    task automatic expect_dump(input logic [3:0] q0, input logic [7:0] d [6], input int n);
        repeat (2) @(posedge link_clk);
        for (int i = 0; i < n; i++)
        begin
            chk("dump word", {4'(q0 + i), 8'h00, d[i]}, out_word);
            chk("dump strobe", 1, output_byte_strobe);
            @(posedge link_clk);
        end
        chk("dump end", 0, output_byte_strobe);
    endtask

    task automatic t_status();
        chk("status", 8'hE0, health_status);
        @(posedge core_clk);
        watchdog_reset_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("status", 8'hF0, health_status);
        core_pulse(2);
        @(posedge core_clk);
        chk("status action", 1, status_write_action);
        chk("status", 8'hF0, health_status);
    endtask

    task automatic t_ext();
        u_tx.send_cmd(MY_ID[13:0] ^ 14'h0001, 1'b1, 8'h11, 8'h22);
        repeat (6) @(posedge link_clk);
        chk("foreign strobe", 0, output_byte_strobe);
        u_tx.send_cmd(MY_ID[13:0], 1'b1, 8'h5A, 8'h3C);
        @(posedge link_clk);
        chk("ext strobe", 1, output_byte_strobe);
        chk("ext word", 20'h03C5A, out_word);
        @(posedge link_clk);
        chk("ext strobe", 0, output_byte_strobe);
    endtask

    task automatic t_regs();
        logic [7:0] d [6] = '{8'h81, 8'h42, 8'h24, 8'h18, MY_ID[7:0], {2'b00, MY_ID[13:8]}};
        for (int i = 0; i < 4; i++)
            u_tx.send_cmd(14'h0000, 1'b0, d[i], 8'(i));
        u_tx.send_cmd(14'h0000, 1'b0, 8'hFF, 8'h07);
        @(posedge link_clk);
        chk("regs", {d[0], d[1], d[2], d[3]}, {fine_delay_one, fine_delay_two, coarse_delay, control});
        u_tx.send_cmd(14'h0000, 1'b0, 8'h77, 8'h05);
        expect_dump(4'h5, d, 6);
    endtask

    task automatic t_errors();
        logic [7:0] d [6] = '{8'h03, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
        for (int k = 0; k < 3; k++)
            repeat (3 - k) u_tx.pulse(k);
        u_tx.send_cmd(MY_ID[13:0], 1'b0, 8'hFF, 8'h04);
        expect_dump(4'h1, d, 4);
    endtask

    task automatic t_counters();
        for (int b = 1; b < 4; b++)
        begin
            u_tx.pulse(3);
            repeat (3) @(posedge link_clk);
            u_tx.bcast(8'(b) | 8'hA4);
            @(posedge link_clk);
            chk("bunch cleared", b[0], bunch_count == '0);
            chk("event cleared", b[1], event_count == '0);
        end
        repeat (6) @(posedge link_clk);
        chk("bunch count", 6, bunch_count);
        repeat (5) u_tx.pulse(3);
        @(posedge link_clk);
        chk("event count", 5, event_count);
        core_pulse(1);
        core_pulse(0);
        repeat (6) @(posedge link_clk);
        chk("event write clear", 0, event_count);
        chk("bunch write clear", 1, bunch_count < 12'h00A);
    endtask

    task automatic t_reset_cmd();
        logic [7:0] w;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge core_clk);
            pll_lock_pin <= p[0];
            repeat (3) @(posedge core_clk);
            chk("status", {p[0], 7'h70}, health_status);
            u_tx.send_cmd(14'h0000, 1'b0, 8'h00, 8'h06);
            w = 8'h00;
            repeat (20) @(posedge core_clk) w += chip_reset_request;
            chk("reset request", p, w);
        end
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge link_clk);
        t_status();
        t_ext();
        t_regs();
        t_errors();
        t_counters();
        t_reset_cmd();
        stop_test();
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end
endmodule

bind addressed_command_decoder cmd_decoder_monitor #(.BUNCH_W(BUNCH_W), .EVENT_W(EVENT_W)) u_mon (.*);
`default_nettype wire
